// file: ytm_yearly_timer.sv
// yearly date timer: APB registers, midnight-gated scan evaluation, output
`timescale 1ns/1ps

module ytm_yearly_timer (
   // clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // APB slave
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // calendar source
   input wire logic [11:0] calYear,
   input wire logic [3:0] calMonth,
   input wire logic [4:0] calDay,
   // program scan strobe
   input wire logic scanTick,
   // timer output
   output logic timerOut
);
   function automatic ytm_pkg::ytm_date_t word_to_date(input logic [31:0] w);
      ytm_pkg::ytm_date_t d;
      d.year = w[ytm_pkg::DATE_YEAR_LSB +: ytm_pkg::YEAR_W];
      d.month = w[ytm_pkg::DATE_MONTH_LSB +: ytm_pkg::MONTH_W];
      d.day = w[ytm_pkg::DATE_DAY_LSB +: ytm_pkg::DAY_W];
      return d;
   endfunction

   function automatic logic [31:0] date_to_word(input ytm_pkg::ytm_date_t d);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[ytm_pkg::DATE_YEAR_LSB +: ytm_pkg::YEAR_W] = d.year;
      w[ytm_pkg::DATE_MONTH_LSB +: ytm_pkg::MONTH_W] = d.month;
      w[ytm_pkg::DATE_DAY_LSB +: ytm_pkg::DAY_W] = d.day;
      return w;
   endfunction

   // date lies in the supported calendar span
   function automatic logic date_ok(input ytm_pkg::ytm_date_t d);
      date_ok = (d.year >= ytm_pkg::YEAR_MIN) && (d.year <= ytm_pkg::YEAR_MAX) &&
                (d.month >= ytm_pkg::MONTH_MIN) && (d.month <= ytm_pkg::MONTH_MAX) &&
                (d.day >= ytm_pkg::DAY_MIN) && (d.day <= ytm_pkg::DAY_MAX);
   endfunction

   logic [3:0] ctrl_r;
   ytm_pkg::ytm_date_t onDate_r;
   ytm_pkg::ytm_date_t offDate_r;
   logic refused_r;
   logic [31:0] rdata_r;
   logic err_r;
   ytm_pkg::ytm_date_t lastDate_r;
   logic seen_r;
   logic out_r;
   logic out_nxt;

   ytm_pkg::ytm_date_t calDate;
   ytm_pkg::ytm_mode_t mode;
   logic enable;
   logic pulseSel;
   logic setupPhase;
   logic accessPhase;
   logic wrDone;
   logic wrOn;
   logic wrOff;
   logic wrCtrl;
   logic dayNew;
   logic camLevel;
   logic camHit;

   ytm_cam_if cam ();

   assign calDate = '{year: calYear, month: calMonth, day: calDay};
   assign enable = ctrl_r[ytm_pkg::CTRL_ENABLE];
   assign pulseSel = ctrl_r[ytm_pkg::CTRL_PULSE];

   // monthly takes precedence over yearly
   always_comb begin
      if (ctrl_r[ytm_pkg::CTRL_MONTHLY]) begin
         mode = ytm_pkg::MODE_MONTHLY;
      end else if (ctrl_r[ytm_pkg::CTRL_YEARLY]) begin
         mode = ytm_pkg::MODE_YEARLY;
      end else begin
         mode = ytm_pkg::MODE_SPAN;
      end
   end

   assign cam.curDate = calDate;
   assign cam.onDate = onDate_r;
   assign cam.offDate = offDate_r;
   assign cam.mode = mode;
   assign camLevel = cam.level;
   assign camHit = cam.hit;

   ytm_date_eval u_eval (
      .cam(cam.eval)
   );

   // ---------------- APB slave ----------------
   assign setupPhase = psel && !penable;
   assign accessPhase = psel && penable;
   assign pready = accessPhase;
   assign prdata = rdata_r;
   assign pslverr = accessPhase && err_r;

   assign wrDone = accessPhase && pwrite && !err_r;
   assign wrCtrl = wrDone && (paddr == ytm_pkg::ADDR_CTRL);
   assign wrOn = wrDone && (paddr == ytm_pkg::ADDR_ON_DATE);
   assign wrOff = wrDone && (paddr == ytm_pkg::ADDR_OFF_DATE);

   // read data and error are decided in the setup cycle
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rdata_r <= 32'h0000_0000;
      end else if (setupPhase) begin
         rdata_r <= 32'h0000_0000;
         if (!pwrite) begin
            unique case (paddr)
               ytm_pkg::ADDR_CTRL: rdata_r <= {28'h000_0000, ctrl_r};
               ytm_pkg::ADDR_ON_DATE: rdata_r <= date_to_word(onDate_r);
               ytm_pkg::ADDR_OFF_DATE: rdata_r <= date_to_word(offDate_r);
               ytm_pkg::ADDR_STATUS: rdata_r <= {29'h0000_0000, refused_r, camLevel, out_r};
               default: rdata_r <= 32'h0000_0000;
            endcase
         end
      end
   end

   // out-of-span dates, status writes and unmapped addresses are refused
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         err_r <= 1'b0;
      end else if (setupPhase) begin
         unique case (paddr)
            ytm_pkg::ADDR_CTRL: err_r <= 1'b0;
            ytm_pkg::ADDR_ON_DATE: err_r <= pwrite && !date_ok(word_to_date(pwdata));
            ytm_pkg::ADDR_OFF_DATE: err_r <= pwrite && !date_ok(word_to_date(pwdata));
            ytm_pkg::ADDR_STATUS: err_r <= pwrite;
            default: err_r <= 1'b1;
         endcase
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         refused_r <= 1'b0;
      end else if (accessPhase && pwrite) begin
         refused_r <= err_r;
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl_r <= ytm_pkg::CTRL_RESET;
      end else if (wrCtrl) begin
         ctrl_r <= pwdata[3:0];
      end
   end

   // date words unpack as year, month, day
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         onDate_r <= ytm_pkg::DATE_RESET;
      end else if (wrOn) begin
         onDate_r <= word_to_date(pwdata);
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         offDate_r <= ytm_pkg::DATE_RESET;
      end else if (wrOff) begin
         offDate_r <= word_to_date(pwdata);
      end
   end

   // ---------------- scan evaluation ----------------
   // a new day is an enabled scan whose calendar date differs from the last scan, or the first enabled scan after a disabled one
   assign dayNew = scanTick && enable && (!seen_r || (calDate != lastDate_r));

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         lastDate_r <= ytm_pkg::DATE_RESET;
         seen_r <= 1'b0;
      end else if (scanTick) begin
         lastDate_r <= calDate;
         seen_r <= enable;
      end
   end

   always_comb begin
      out_nxt = out_r;
      if (scanTick) begin
         if (!enable || !date_ok(calDate)) begin
            out_nxt = 1'b0;
         end else if (dayNew) begin
            // level follows the cam, pulse follows the activation date
            out_nxt = pulseSel ? camHit : camLevel;
         end else if (pulseSel) begin
            out_nxt = 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         out_r <= 1'b0;
      end else begin
         out_r <= out_nxt;
      end
   end

   assign timerOut = out_r;

   // ---------------- checks ----------------
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (sys_rst);

   sequence s_new_day;
      scanTick && dayNew && date_ok(calDate);
   endsequence

   sequence s_pulse_set;
      s_new_day and (pulseSel && camHit);
   endsequence

   sequence s_quiet_scan;
      scanTick && enable && !dayNew;
   endsequence

   a_out_on_scan: assert property (
      !$stable(timerOut) |-> $past(scanTick))
      else $error("timer output moved without a scan");

   a_set_at_midnight: assert property (
      $rose(timerOut) |-> $past(dayNew))
      else $error("timer output set outside a day change");

   a_refuse_span: assert property (
      (setupPhase && pwrite && (paddr == ytm_pkg::ADDR_ON_DATE) &&
       (pwdata[ytm_pkg::DATE_YEAR_LSB +: ytm_pkg::YEAR_W] > ytm_pkg::YEAR_MAX))
      ##1 accessPhase |-> pslverr ##1 (onDate_r == $past(onDate_r, 2)))
      else $error("out-of-span on date was accepted");

   a_off_refused: assert property (
      (setupPhase && pwrite && (paddr == ytm_pkg::ADDR_OFF_DATE) &&
       !date_ok(word_to_date(pwdata)))
      ##1 accessPhase |-> pslverr ##1 (offDate_r == $past(offDate_r, 2)))
      else $error("invalid off date was accepted");

   a_on_write: assert property (
      wrOn |=> (onDate_r == $past(word_to_date(pwdata))))
      else $error("on date not stored as year, month, day");

   a_level_follow: assert property (
      (s_new_day and !pulseSel) |=> (timerOut == $past(camLevel)))
      else $error("timer output differs from cam level");

   a_pulse_one_scan: assert property (
      (s_quiet_scan and (pulseSel && timerOut)) |=> !timerOut)
      else $error("pulse lasted beyond one scan");

   a_pulse_rises: assert property (
      s_pulse_set |=> timerOut)
      else $error("pulse missing on activation date");

   a_single_pulse: assert property (
      (s_new_day and (pulseSel && (mode == ytm_pkg::MODE_SPAN) &&
                      (calDate != onDate_r))) |=> !timerOut)
      else $error("single pulse on a date other than the on date");

   a_span_hold: assert property (
      (s_new_day and (!pulseSel && (mode == ytm_pkg::MODE_SPAN) &&
                      (calDate >= onDate_r) && (calDate < offDate_r))) |=> timerOut)
      else $error("span output low inside on/off dates");

   a_off_day_low: assert property (
      (s_new_day and (!pulseSel && (mode == ytm_pkg::MODE_SPAN) &&
                      (calDate == offDate_r))) |=> !timerOut)
      else $error("output high on the off date");

   a_yearly_wrap: assert property (
      (s_new_day and (!pulseSel && (mode == ytm_pkg::MODE_YEARLY) &&
                      ({onDate_r.month, onDate_r.day} > {offDate_r.month, offDate_r.day}) &&
                      ({calMonth, calDay} < {offDate_r.month, offDate_r.day}) &&
                      (calYear > onDate_r.year) && (calYear <= offDate_r.year)))
      |=> timerOut)
      else $error("yearly window did not carry into the next year");

   a_yearly_bound: assert property (
      (s_new_day and ((mode == ytm_pkg::MODE_YEARLY) &&
                      ((calYear > offDate_r.year) || (calYear < onDate_r.year))))
      |=> !timerOut)
      else $error("yearly output outside the year span");

   a_monthly_on: assert property (
      (s_new_day and (!pulseSel && (mode == ytm_pkg::MODE_MONTHLY) &&
                      (calDay == onDate_r.day) && (onDate_r.day < offDate_r.day) &&
                      (calYear >= onDate_r.year) && (calYear <= offDate_r.year)))
      |=> timerOut)
      else $error("monthly output not set on the on day");

   a_monthly_stop: assert property (
      (s_new_day and ((mode == ytm_pkg::MODE_MONTHLY) && (calYear > offDate_r.year)))
      |=> !timerOut)
      else $error("monthly output active after the final year");

   a_yearly_final: assert property (
      (s_new_day and (!pulseSel && (mode == ytm_pkg::MODE_YEARLY) &&
                      ({onDate_r.month, onDate_r.day} > {offDate_r.month, offDate_r.day}) &&
                      ({calMonth, calDay} >= {offDate_r.month, offDate_r.day}) &&
                      (calYear == offDate_r.year)))
      |=> !timerOut)
      else $error("yearly output came back after the final off date");

   a_same_day_hold: assert property (
      (s_quiet_scan and !pulseSel) |=> $stable(timerOut))
      else $error("level output moved without a day change");

   a_disable_clear: assert property (
      (scanTick && !enable) |=> !timerOut)
      else $error("disabled timer kept its output high");

   a_bad_date_clear: assert property (
      (scanTick && enable && !date_ok(calDate)) |=> !timerOut)
      else $error("output high on a calendar date outside the span");
endmodule

// file: ytm_pkg.sv
// constants, date type and mode encoding of the yearly date timer
package ytm_pkg;
   // calendar field widths
   localparam int YEAR_W = 12;
   localparam int MONTH_W = 4;
   localparam int DAY_W = 5;

   // fields in declaration order give year, then month, then day
   typedef struct packed {
      logic [11:0] year;
      logic [3:0] month;
      logic [4:0] day;
   } ytm_date_t;

   // accepted calendar span
   localparam logic [11:0] YEAR_MIN = 12'h7D0;
   localparam logic [11:0] YEAR_MAX = 12'h833;
   localparam logic [3:0] MONTH_MIN = 4'h1;
   localparam logic [3:0] MONTH_MAX = 4'hC;
   localparam logic [4:0] DAY_MIN = 5'h01;
   localparam logic [4:0] DAY_MAX = 5'h1F;

   // register byte offsets
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_ON_DATE = 8'h04;
   localparam logic [7:0] ADDR_OFF_DATE = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h0C;

   // control and status bit positions
   localparam int CTRL_ENABLE = 0;
   localparam int CTRL_YEARLY = 1;
   localparam int CTRL_MONTHLY = 2;
   localparam int CTRL_PULSE = 3;
   localparam int STAT_OUT = 0;
   localparam int STAT_LEVEL = 1;
   localparam int STAT_REFUSED = 2;

   // date word layout
   localparam int DATE_DAY_LSB = 0;
   localparam int DATE_MONTH_LSB = 8;
   localparam int DATE_YEAR_LSB = 16;

   // values after reset
   localparam logic [3:0] CTRL_RESET = 4'h0;
   localparam ytm_date_t DATE_RESET = '{year: 12'h7D0, month: 4'h1, day: 5'h01};

   typedef enum logic [1:0] {
      MODE_SPAN = 2'b00,
      MODE_YEARLY = 2'b01,
      MODE_MONTHLY = 2'b10
   } ytm_mode_t;
endpackage

// file: ytm_cam_if.sv
// dates and mode into the date evaluator, cam state back out
`timescale 1ns/1ps
interface ytm_cam_if;
   ytm_pkg::ytm_date_t curDate;
   ytm_pkg::ytm_date_t onDate;
   ytm_pkg::ytm_date_t offDate;
   ytm_pkg::ytm_mode_t mode;
   logic level;
   logic hit;

   modport eval (
      input curDate,
      input onDate,
      input offDate,
      input mode,
      output level,
      output hit
   );

   modport src (
      output curDate,
      output onDate,
      output offDate,
      output mode,
      input level,
      input hit
   );
endinterface

// file: ytm_date_eval.sv
// combinational date comparison: cam level and activation-date hit
`timescale 1ns/1ps
module ytm_date_eval (
   // dates and mode in, cam state out
   ytm_cam_if.eval cam
);
   function automatic logic [8:0] month_day(input ytm_pkg::ytm_date_t d);
      month_day = {d.month, d.day};
   endfunction

   logic yrOk;
   logic [8:0] curMd;
   logic [8:0] onMd;
   logic [8:0] offMd;

   always_comb begin
      curMd = month_day(cam.curDate);
      onMd = month_day(cam.onDate);
      offMd = month_day(cam.offDate);
      yrOk = (cam.curDate.year >= cam.onDate.year) &&
             (cam.curDate.year <= cam.offDate.year);
      cam.level = 1'b0;
      cam.hit = 1'b0;
      unique case (cam.mode)
         ytm_pkg::MODE_SPAN: begin
            // whole dates compare as year, month, day keys
            cam.level = (cam.curDate >= cam.onDate) && (cam.curDate < cam.offDate);
            cam.hit = (cam.curDate == cam.onDate);
         end
         ytm_pkg::MODE_YEARLY: begin
            if (onMd <= offMd) begin
               cam.level = yrOk && (curMd >= onMd) && (curMd < offMd);
            end else begin
               // window wraps into the next year, ends in the final year
               cam.level = ((curMd >= onMd) && (cam.curDate.year >= cam.onDate.year) &&
                            (cam.curDate.year < cam.offDate.year)) ||
                           ((curMd < offMd) && (cam.curDate.year > cam.onDate.year) &&
                            (cam.curDate.year <= cam.offDate.year));
            end
            cam.hit = yrOk && (curMd == onMd);
         end
         ytm_pkg::MODE_MONTHLY: begin
            // every month of the years from on year through off year
            if (cam.onDate.day <= cam.offDate.day) begin
               cam.level = yrOk && (cam.curDate.day >= cam.onDate.day) &&
                           (cam.curDate.day < cam.offDate.day);
            end else begin
               cam.level = yrOk && ((cam.curDate.day >= cam.onDate.day) ||
                                    (cam.curDate.day < cam.offDate.day));
            end
            cam.hit = yrOk && (cam.curDate.day == cam.onDate.day);
         end
         default: begin
            cam.level = 1'b0;
            cam.hit = 1'b0;
         end
      endcase
   end
endmodule

// file: ytm_cal_src.sv
// calendar source and scan strobe model that feeds the date timer
`timescale 1ns/1ps
module ytm_cal_src (
   // clock
   input wire logic ref_clk,
   // calendar date and scan strobe
   output logic [11:0] calYear,
   output logic [3:0] calMonth,
   output logic [4:0] calDay,
   output logic scanTick
);
   initial begin
      calYear = 12'h7D0;
      calMonth = 4'h1;
      calDay = 5'h01;
      scanTick = 1'b0;
   end

   // one program scan: date moves with the strobe, strobe high one cycle
   task automatic scan(input logic [11:0] y, input logic [3:0] m, input logic [4:0] d);
      @(posedge ref_clk);
      calYear <= y;
      calMonth <= m;
      calDay <= d;
      scanTick <= 1'b1;
      @(posedge ref_clk);
      scanTick <= 1'b0;
   endtask
endmodule

// file: testbench.sv
// self-checking bench: APB register access and date scans
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samplesChecked++; if ((g) !== (e)) begin failCount++; \
   $display("unexpected %s expected %0h seen %0h", nm, e, g); end end
module testbench;
   logic ref_clk, sys_rst, psel, penable, pwrite, pready, pslverr, scanTick, timerOut;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [11:0] calYear;
   logic [3:0] calMonth;
   logic [4:0] calDay;
   int failCount = 0;
   int samplesChecked = 0;
   int cycles = 0;

   ytm_yearly_timer dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .calYear(calYear), .calMonth(calMonth), .calDay(calDay),
      .scanTick(scanTick), .timerOut(timerOut));
   ytm_cal_src cal (.ref_clk(ref_clk), .calYear(calYear), .calMonth(calMonth),
      .calDay(calDay), .scanTick(scanTick));

   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end

   function automatic logic [31:0] dw(logic [11:0] y, logic [3:0] m, logic [4:0] d);
      return {4'h0, y, 4'h0, m, 3'h0, d};
   endfunction

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", samplesChecked, failCount);
      if (failCount == 0 && samplesChecked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         failCount++;
         give_verdict();
      end
   end

   // one APB transfer; request held until pready is seen high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
         output logic [31:0] rd, output logic err);
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] wd, input logic eErr);
      logic [31:0] rd;
      logic err;
      apb(1'b1, a, wd, rd, err);
      `CHK("write error", eErr, err)
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic eErr);
      logic [31:0] v;
      logic err;
      apb(1'b0, a, 32'h0, v, err);
      `CHK("read error", eErr, err)
      `CHK("read data", e, v)
   endtask

   task automatic cfg(input logic [31:0] c, input logic [31:0] on, input logic [31:0] off);
      wr(ytm_pkg::ADDR_ON_DATE, on, 1'b0);
      wr(ytm_pkg::ADDR_OFF_DATE, off, 1'b0);
      wr(ytm_pkg::ADDR_CTRL, c, 1'b0);
   endtask

   task automatic step(input logic [11:0] y, input logic [3:0] m, input logic [4:0] d,
         input logic e);
      cal.scan(y, m, d);
      @(negedge ref_clk);
      `CHK("timerOut", e, timerOut)
   endtask

   initial begin
      sys_rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (8) @(posedge ref_clk);
      sys_rst <= 1'b0;
      rd(ytm_pkg::ADDR_CTRL, 32'h0, 1'b0);
      rd(ytm_pkg::ADDR_ON_DATE, 32'h07D00101, 1'b0);
      rd(ytm_pkg::ADDR_STATUS, 32'h0, 1'b0);
      rd(8'h10, 32'h0, 1'b1);
      wr(ytm_pkg::ADDR_STATUS, 32'h1, 1'b1);
      $display("test reset and map done");

      wr(ytm_pkg::ADDR_ON_DATE, dw(12'h834, 4'h1, 5'h01), 1'b1);
      wr(ytm_pkg::ADDR_ON_DATE, dw(12'h7CF, 4'hC, 5'h1F), 1'b1);
      wr(ytm_pkg::ADDR_OFF_DATE, dw(12'h7D8, 4'hD, 5'h01), 1'b1);
      wr(ytm_pkg::ADDR_OFF_DATE, dw(12'h7D8, 4'h1, 5'h00), 1'b1);
      rd(ytm_pkg::ADDR_STATUS, 32'h4, 1'b0);
      rd(ytm_pkg::ADDR_ON_DATE, 32'h07D00101, 1'b0);
      wr(ytm_pkg::ADDR_OFF_DATE, dw(12'h833, 4'hC, 5'h1F), 1'b0);
      rd(ytm_pkg::ADDR_OFF_DATE, dw(12'h833, 4'hC, 5'h1F), 1'b0);
      rd(ytm_pkg::ADDR_STATUS, 32'h2, 1'b0);
      $display("test date range done");

      cfg(32'h1, dw(12'h7D8, 4'h6, 5'h01), dw(12'h7DA, 4'h8, 5'h1F));
      step(12'h7D8, 4'h5, 5'h1F, 1'b0);
      step(12'h7D8, 4'h6, 5'h01, 1'b1);
      step(12'h7D9, 4'hC, 5'h1F, 1'b1);
      step(12'h7DA, 4'h8, 5'h1E, 1'b1);
      step(12'h7DA, 4'h8, 5'h1F, 1'b0);
      cfg(32'h1, dw(12'h7DA, 4'h8, 5'h01), dw(12'h7DA, 4'h9, 5'h1E));
      step(12'h7DA, 4'h8, 5'h1F, 1'b0);
      step(12'h7DA, 4'h9, 5'h01, 1'b1);
      rd(ytm_pkg::ADDR_STATUS, 32'h3, 1'b0);
      step(12'h7DA, 4'h0, 5'h02, 1'b0);
      step(12'h7DA, 4'h9, 5'h03, 1'b1);
      wr(ytm_pkg::ADDR_CTRL, 32'h0, 1'b0);
      step(12'h7DA, 4'h9, 5'h04, 1'b0);
      $display("test span done");

      cfg(32'h3, dw(12'h7D8, 4'h6, 5'h01), dw(12'h7DA, 4'h8, 5'h1F));
      step(12'h7D7, 4'h7, 5'h01, 1'b0);
      step(12'h7D9, 4'h5, 5'h1F, 1'b0);
      step(12'h7D9, 4'h6, 5'h01, 1'b1);
      step(12'h7D9, 4'h8, 5'h1E, 1'b1);
      step(12'h7D9, 4'h8, 5'h1F, 1'b0);
      step(12'h7DB, 4'h7, 5'h01, 1'b0);
      cfg(32'h3, dw(12'h7D8, 4'hC, 5'h0F), dw(12'h7DA, 4'h1, 5'h07));
      step(12'h7D8, 4'h1, 5'h03, 1'b0);
      step(12'h7D8, 4'hC, 5'h0F, 1'b1);
      step(12'h7D9, 4'h1, 5'h06, 1'b1);
      step(12'h7D9, 4'hC, 5'h14, 1'b1);
      step(12'h7DA, 4'h1, 5'h07, 1'b0);
      step(12'h7DA, 4'hC, 5'h0F, 1'b0);
      $display("test yearly done");

      cfg(32'h5, dw(12'h7D8, 4'h1, 5'h01), dw(12'h7DA, 4'h1, 5'h05));
      step(12'h7D7, 4'hC, 5'h02, 1'b0);
      step(12'h7D8, 4'h3, 5'h04, 1'b1);
      step(12'h7D8, 4'h3, 5'h05, 1'b0);
      step(12'h7DA, 4'hC, 5'h03, 1'b1);
      step(12'h7DA, 4'hC, 5'h05, 1'b0);
      step(12'h7DB, 4'h1, 5'h02, 1'b0);
      $display("test monthly done");

      cfg(32'hB, dw(12'h7D8, 4'h3, 5'h0F), dw(12'h7DA, 4'h1, 5'h01));
      step(12'h7D9, 4'h3, 5'h0E, 1'b0);
      step(12'h7D9, 4'h3, 5'h0F, 1'b1);
      step(12'h7D9, 4'h3, 5'h0F, 1'b0);
      step(12'h7DB, 4'h3, 5'h0F, 1'b0);
      cfg(32'h9, dw(12'h7D8, 4'h3, 5'h0F), dw(12'h7DA, 4'h1, 5'h01));
      step(12'h7D9, 4'h3, 5'h0F, 1'b0);
      step(12'h7D8, 4'h3, 5'h0F, 1'b1);
      step(12'h7D8, 4'h3, 5'h10, 1'b0);
      $display("test pulse done");
      give_verdict();
   end
endmodule
